//--- rtl/od_decoder.sv
// Opcode decoder and instruction sequencer for an 8-bit core.
// Assumes program memory on the same clock answers code_req_o with
// code_valid_i and the byte; ext_sel_i and break_release_i are synchronous.
//
// Functional notes
// - Machine cycle equals two system clocks
// - Fetch one to three bytes per opcode
// - Execute in 1, 2 or 4 cycles
// - Register number from low three bits
// - Top opcode bits give address page
// - Register add and add-with-carry decode
// - Subtract with borrow register and immediate
// - Logic immediate to direct: 3B, 2C
// - Rotates through carry, one byte one cycle
// - Code byte move from pointer or PC
// - External moves: pointer or register indirect
// - Direct to direct move: 3B, 2C
// - Push and pop: two bytes, two cycles
// - Low nibble exchange in one cycle
// - Carry with inverted bit, AND/OR
// - Branch on bit set, then clear it
// - Compare branch not equal: 3B, 2C
// - Decrement branch nonzero lengths differ by operand
// - Long call and jump: 3B, 2C
// - Indirect jump on accumulator plus pointer
// - Extended select picks store or break
`timescale 1ns/10ps
`include "od_regs.svh"
module od_decoder import od_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic code_valid_i,
	input wire logic [7:0] code_byte_i,
	input wire logic [3:0] ext_sel_i,
	input wire logic break_release_i,
	output logic code_req_o,
	output logic [7:0] opcode_o,
	output od_dec_t dec_o,
	output logic [7:0] operand1_o,
	output logic [7:0] operand2_o,
	output logic issue_o,
	output logic done_o,
	output logic break_o,
	output logic halted_o
);
	od_state_t s_r;
	od_state_t s_nxt;
	logic mc_tick;
	od_dec_t dec_w;
	logic take_w;

	// --------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------
	function automatic od_dec_t mk(od_kind_t k, od_mode_t m, logic [1:0] l,
		logic [2:0] c, logic [3:0] f);
		od_dec_t d;
		d.kind = k;
		d.mode = m;
		d.reg_num = 3'h0;
		d.len = l;
		d.cyc = c;
		d.flags = f;
		d.page = 3'h0;
		return d;
	endfunction

	// Hand over to execution; the divider restarts on this edge,
	// so the issue edge is the first clock of machine cycle one
	function automatic od_state_t start_exec(od_state_t s, od_dec_t d);
		od_state_t t;
		t = s;
		t.st = S_EXEC;
		t.mc_left = d.cyc;
		t.div_clr = 1'b1;
		t.issue = 1'b1;
		return t;
	endfunction

	// Request stands in both fetch states
	function automatic logic wants_byte(od_st_t st);
		return (st == S_FETCH) || (st == S_OPER);
	endfunction

	// Operand class of the low column in register-indexed rows
	function automatic od_mode_t col_mode(logic [7:0] op);
		od_mode_t m;
		m = M_REG;
		if (op[3:0] == 4'h4) begin
			m = M_IMM;
		end else if (op[3:0] == 4'h5) begin
			m = M_DIR;
		end else if (op[3:1] == 3'h3) begin
			m = M_IND;
		end
		return m;
	endfunction

	// Accumulator arithmetic and logic rows
	function automatic od_dec_t alu_dec(logic [7:0] op);
		od_dec_t d;
		od_kind_t k;
		logic [3:0] f;
		logic [1:0] l;
		k = K_NOP;
		f = `OD_F_P;
		case (op[7:4])
			4'h2: begin
				k = K_ADD;
				f = `OD_F_ALL;
			end
			4'h3: begin
				k = K_ADD_WITH_CARRY;
				f = `OD_F_ALL;
			end
			4'h4: k = K_ORL;
			4'h5: k = K_ANL;
			4'h6: k = K_XRL;
			4'h9: begin
				k = K_SUBTRACT_WITH_BORROW;
				f = `OD_F_ALL;
			end
			default: k = K_NOP;
		endcase
		// Immediate and direct forms carry one operand byte
		l = (op[3:1] == 3'h2) ? `OD_L2 : `OD_L1;
		d = mk(k, col_mode(op), l, `OD_C1, f);
		return d;
	endfunction

	function automatic od_dec_t decode(logic [7:0] op, logic [3:0] sel);
		od_dec_t d;
		d = mk(K_NOP, M_NONE, `OD_L1, `OD_C1, `OD_F_NONE);
		casez (op)
			8'h00: d = mk(K_NOP, M_NONE, `OD_L1, `OD_C1, `OD_F_NONE);
			8'b???0_0001: d = mk(K_ABS_JUMP, M_ADDR11, `OD_L2, `OD_C2, `OD_F_NONE);
			8'b???1_0001: d = mk(K_ABS_CALL, M_ADDR11, `OD_L2, `OD_C2, `OD_F_NONE);
			8'h02: d = mk(K_LONG_JUMP, M_ADDR16, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h12: d = mk(K_LONG_CALL, M_ADDR16, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h22: d = mk(K_RET, M_NONE, `OD_L1, `OD_C2, `OD_F_NONE);
			8'h32: d = mk(K_RETI, M_NONE, `OD_L1, `OD_C2, `OD_F_NONE);
			8'h03: d = mk(K_RR, M_ACC, `OD_L1, `OD_C1, `OD_F_NONE);
			8'h13: d = mk(K_ROTATE_RIGHT_THROUGH_CARRY, M_ACC, `OD_L1, `OD_C1,
				`OD_F_CYP);
			8'h23: d = mk(K_RL, M_ACC, `OD_L1, `OD_C1, `OD_F_NONE);
			8'h33: d = mk(K_ROTATE_LEFT_THROUGH_CARRY, M_ACC, `OD_L1, `OD_C1,
				`OD_F_CYP);
			8'h04: d = mk(K_INC, M_ACC, `OD_L1, `OD_C1, `OD_F_P);
			8'h14: d = mk(K_DEC, M_ACC, `OD_L1, `OD_C1, `OD_F_P);
			8'h05: d = mk(K_INC, M_DIR, `OD_L2, `OD_C1, `OD_F_NONE);
			8'h15: d = mk(K_DEC, M_DIR, `OD_L2, `OD_C1, `OD_F_NONE);
			8'b0000_011?, 8'b0000_1???: d = mk(K_INC, col_mode(op), `OD_L1, `OD_C1, `OD_F_NONE);
			8'b0001_011?, 8'b0001_1???: d = mk(K_DEC, col_mode(op), `OD_L1, `OD_C1, `OD_F_NONE);
			8'h10: d = mk(K_BRANCH_BIT_SET_THEN_CLEAR, M_BIT, `OD_L3, `OD_C2,
				`OD_F_NONE);
			8'h20: d = mk(K_JB, M_BIT, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h30: d = mk(K_JNB, M_BIT, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h40: d = mk(K_JC, M_REL, `OD_L2, `OD_C2, `OD_F_NONE);
			8'h50: d = mk(K_JNC, M_REL, `OD_L2, `OD_C2, `OD_F_NONE);
			8'h60: d = mk(K_JZ, M_REL, `OD_L2, `OD_C2, `OD_F_NONE);
			8'h70: d = mk(K_JNZ, M_REL, `OD_L2, `OD_C2, `OD_F_NONE);
			8'h80: d = mk(K_SJMP, M_REL, `OD_L2, `OD_C2, `OD_F_NONE);
			8'h42: d = mk(K_ORL, M_DIR, `OD_L2, `OD_C1, `OD_F_NONE);
			8'h52: d = mk(K_ANL, M_DIR, `OD_L2, `OD_C1, `OD_F_NONE);
			8'h62: d = mk(K_XRL, M_DIR, `OD_L2, `OD_C1, `OD_F_NONE);
			8'h43: d = mk(K_ORL, M_DIR_IMM, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h53: d = mk(K_ANL, M_DIR_IMM, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h63: d = mk(K_XRL, M_DIR_IMM, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h72: d = mk(K_ORL_C, M_BIT, `OD_L2, `OD_C2, `OD_F_CY);
			8'h82: d = mk(K_ANL_C, M_BIT, `OD_L2, `OD_C2, `OD_F_CY);
			8'ha0: d = mk(K_ORL_CN, M_BIT, `OD_L2, `OD_C2, `OD_F_CY);
			8'hb0: d = mk(K_ANL_CN, M_BIT, `OD_L2, `OD_C2, `OD_F_CY);
			8'h73: d = mk(K_JMP_IND, M_CODE_DP, `OD_L1, `OD_C2, `OD_F_NONE);
			8'h74: d = mk(K_MOV, M_IMM, `OD_L2, `OD_C1, `OD_F_P);
			8'h75: d = mk(K_MOV, M_DIR_IMM, `OD_L3, `OD_C2, `OD_F_NONE);
			8'b0111_011?, 8'b0111_1???: d = mk(K_MOV, col_mode(op), `OD_L2, `OD_C1, `OD_F_NONE);
			8'h83: d = mk(K_CODE_MOVE, M_CODE_PC, `OD_L1, `OD_C2, `OD_F_P);
			8'h93: d = mk(K_CODE_MOVE, M_CODE_DP, `OD_L1, `OD_C2, `OD_F_P);
			8'h84: d = mk(K_DIV, M_ACC, `OD_L1, `OD_C4, `OD_F_MULDIV);
			8'ha4: d = mk(K_MUL, M_ACC, `OD_L1, `OD_C4, `OD_F_MULDIV);
			8'h85: d = mk(K_MOV, M_DIR_DIR, `OD_L3, `OD_C2, `OD_F_NONE);
			8'b1000_011?, 8'b1000_1???: d = mk(K_MOV, col_mode(op), `OD_L2, `OD_C2, `OD_F_NONE);
			8'h90: d = mk(K_MOV_DP, M_IMM, `OD_L3, `OD_C2, `OD_F_NONE);
			8'h92: d = mk(K_MOV_BITC, M_BIT, `OD_L2, `OD_C2, `OD_F_NONE);
			8'ha2: d = mk(K_MOV_CBIT, M_BIT, `OD_L2, `OD_C1, `OD_F_CY);
			8'ha3: d = mk(K_INC_DP, M_NONE, `OD_L1, `OD_C2, `OD_F_NONE);
			8'ha5: begin
				if (sel[3:0] == `OD_EXT_SEL_STORE) begin
					d = mk(K_CODE_STORE, M_CODE_DP, `OD_L1, `OD_C2, `OD_F_NONE);
				end else begin
					d = mk(K_BREAK, M_NONE, `OD_L1, `OD_C1, `OD_F_NONE);
				end
			end
			8'b1010_011?, 8'b1010_1???: d = mk(K_MOV, col_mode(op), `OD_L2, `OD_C2, `OD_F_NONE);
			8'hb2: d = mk(K_BIT_CPL, M_BIT, `OD_L2, `OD_C1, `OD_F_NONE);
			8'hb3: d = mk(K_BIT_CPL, M_NONE, `OD_L1, `OD_C1, `OD_F_CY);
			8'hc2: d = mk(K_BIT_CLR, M_BIT, `OD_L2, `OD_C1, `OD_F_NONE);
			8'hc3: d = mk(K_BIT_CLR, M_NONE, `OD_L1, `OD_C1, `OD_F_CY);
			8'hd2: d = mk(K_BIT_SET, M_BIT, `OD_L2, `OD_C1, `OD_F_NONE);
			8'hd3: d = mk(K_BIT_SET, M_NONE, `OD_L1, `OD_C1, `OD_F_CY);
			8'hb4: d = mk(K_CMP_BNE, M_IMM, `OD_L3, `OD_C2, `OD_F_CY);
			8'hb5: d = mk(K_CMP_BNE, M_DIR, `OD_L3, `OD_C2, `OD_F_CY);
			8'b1011_011?, 8'b1011_1???: d = mk(K_CMP_BNE, col_mode(op), `OD_L3, `OD_C2, `OD_F_CY);
			8'hc0: d = mk(K_PUSH, M_DIR, `OD_L2, `OD_C2, `OD_F_NONE);
			8'hd0: d = mk(K_POP, M_DIR, `OD_L2, `OD_C2, `OD_F_NONE);
			8'hc4: d = mk(K_SWAP, M_ACC, `OD_L1, `OD_C1, `OD_F_NONE);
			8'hc5: d = mk(K_XCH, M_DIR, `OD_L2, `OD_C1, `OD_F_P);
			8'b1100_011?, 8'b1100_1???: d = mk(K_XCH, col_mode(op), `OD_L1, `OD_C1, `OD_F_P);
			8'hd4: d = mk(K_DA, M_ACC, `OD_L1, `OD_C1, `OD_F_CYP);
			8'hd5: d = mk(K_DEC_BNZ, M_DIR, `OD_L3, `OD_C2, `OD_F_NONE);
			8'b1101_011?: d = mk(K_XCH_NIB, M_IND, `OD_L1, `OD_C1, `OD_F_P);
			8'b1101_1???: d = mk(K_DEC_BNZ, M_REG, `OD_L2, `OD_C2, `OD_F_NONE);
			8'he0: d = mk(K_XMOVE_RD, M_XDP, `OD_L1, `OD_C2, `OD_F_P);
			8'b1110_001?: d = mk(K_XMOVE_RD, M_XRI, `OD_L1, `OD_C2, `OD_F_P);
			8'hf0: d = mk(K_XMOVE_WR, M_XDP, `OD_L1, `OD_C2, `OD_F_NONE);
			8'b1111_001?: d = mk(K_XMOVE_WR, M_XRI, `OD_L1, `OD_C2, `OD_F_NONE);
			8'he4: d = mk(K_CLR, M_ACC, `OD_L1, `OD_C1, `OD_F_P);
			8'hf4: d = mk(K_CPL, M_ACC, `OD_L1, `OD_C1, `OD_F_P);
			8'he5: d = mk(K_MOV, M_DIR, `OD_L2, `OD_C1, `OD_F_P);
			8'hf5: d = mk(K_MOV, M_DIR, `OD_L2, `OD_C1, `OD_F_NONE);
			8'b1110_011?, 8'b1110_1???: d = mk(K_MOV, col_mode(op), `OD_L1, `OD_C1, `OD_F_P);
			8'b1111_011?, 8'b1111_1???: d = mk(K_MOV, col_mode(op), `OD_L1, `OD_C1, `OD_F_NONE);
			default: d = alu_dec(op);
		endcase
		// Register-indexed blocks carry the register in the low bits
		if (d.mode == M_REG) begin
			d.reg_num = op[2:0];
		end else if (d.mode == M_IND || d.mode == M_XRI) begin
			d.reg_num = {2'h0, op[0]};
		end
		if (d.mode == M_ADDR11) begin
			d.page = op[7:5];
		end
		return d;
	endfunction

	assign dec_w = decode(code_byte_i, ext_sel_i);

	// --------------------------------------------------------------
	// Machine cycle timebase
	// --------------------------------------------------------------
	od_mc_div #(
		.DIV(`OD_CLK_PER_MC)
	) u_div (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clr_i(s_nxt.div_clr),
		.tick_o(mc_tick)
	);

	// --------------------------------------------------------------
	// Fetch handshake
	// --------------------------------------------------------------
	// Valid may stand while request is low; that byte waits
	// until the next fetch raises the request again
	assign take_w = s_r.req && code_valid_i;

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.issue = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.brk = 1'b0;
		s_nxt.div_clr = 1'b0;
		case (s_r.st)
			S_FETCH: begin
				if (take_w) begin
					s_nxt.opc = code_byte_i;
					s_nxt.dec = dec_w;
					s_nxt.op1 = 8'h00;
					s_nxt.op2 = 8'h00;
					s_nxt.bytes_left = dec_w.len - `OD_L1;
					if (dec_w.len == `OD_L1) begin
						s_nxt = start_exec(s_nxt, dec_w);
					end else begin
						s_nxt.st = S_OPER;
					end
				end
			end
			S_OPER: begin
				if (take_w) begin
					// First operand lands in op1, a second one in op2
					if (s_r.bytes_left == s_r.dec.len - `OD_L1) begin
						s_nxt.op1 = code_byte_i;
					end else begin
						s_nxt.op2 = code_byte_i;
					end
					s_nxt.bytes_left = s_r.bytes_left - 2'h1;
					if (s_r.bytes_left == 2'h1) begin
						s_nxt = start_exec(s_nxt, s_r.dec);
					end
				end
			end
			S_EXEC: begin
				// Divider restarts at issue, so each count spans two clocks
				if (mc_tick) begin
					s_nxt.mc_left = s_r.mc_left - 3'h1;
					if (s_r.mc_left == 3'h1) begin
						s_nxt.done = 1'b1;
						if (s_r.dec.kind == K_BREAK) begin
							s_nxt.st = S_BREAK;
							s_nxt.brk = 1'b1;
						end else begin
							s_nxt.st = S_FETCH;
						end
					end
				end
			end
			S_BREAK: begin
				// No fetch while halted; debug logic must release
				if (break_release_i) begin
					s_nxt.st = S_FETCH;
				end
			end
			default: s_nxt.st = S_FETCH;
		endcase
		s_nxt.halted = (s_nxt.st == S_BREAK);
		// Request drops once the last byte of an instruction is taken
		s_nxt.req = wants_byte(s_nxt.st);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign code_req_o = s_r.req;
	assign opcode_o = s_r.opc;
	assign dec_o = s_r.dec;
	assign operand1_o = s_r.op1;
	assign operand2_o = s_r.op2;
	assign issue_o = s_r.issue;
	assign done_o = s_r.done;
	assign break_o = s_r.brk;
	assign halted_o = s_r.halted;
endmodule

//--- rtl/od_mc_div.sv
// Machine cycle divider: one-cycle tick every DIV system clocks.
// Assumes the clear input comes from logic on the same clock.
`timescale 1ns/10ps
`include "od_regs.svh"
module od_mc_div import od_pkg::*; #(
	parameter int DIV = `OD_CLK_PER_MC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	output logic tick_o
);
	od_div_state_t s_r;
	od_div_state_t s_nxt;

	// --------------------------------------------------------------
	// Counter
	// --------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (clr_i) begin
			// Issue edge is the first clock; a pending tick is dropped
			s_nxt.cnt = 4'h1;
		end else if (s_r.cnt == 4'(DIV - 1)) begin
			s_nxt.cnt = 4'h0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = s_r.tick;
endmodule

//--- rtl/od_pkg.sv
// Types shared by the opcode decoder and its machine cycle divider.
// Assumes od_regs.svh is on the include path.
package od_pkg;

	// --------------------------------------------------------------
	// Operation and operand classes
	// --------------------------------------------------------------
	typedef enum logic [5:0] {
		K_NOP, K_ADD, K_ADD_WITH_CARRY, K_SUBTRACT_WITH_BORROW, K_INC, K_DEC, K_INC_DP,
		K_MUL, K_DIV, K_DA, K_ANL, K_ORL, K_XRL, K_CLR, K_CPL, K_SWAP, K_RL,
		K_ROTATE_LEFT_THROUGH_CARRY, K_RR, K_ROTATE_RIGHT_THROUGH_CARRY,
		K_MOV, K_MOV_DP, K_CODE_MOVE, K_XMOVE_RD, K_XMOVE_WR, K_PUSH, K_POP,
		K_XCH, K_XCH_NIB, K_BIT_CLR, K_BIT_SET, K_BIT_CPL, K_ANL_C, K_ANL_CN,
		K_ORL_C, K_ORL_CN, K_MOV_CBIT, K_MOV_BITC, K_ABS_CALL, K_LONG_CALL,
		K_RET, K_RETI, K_ABS_JUMP, K_LONG_JUMP, K_SJMP, K_JC, K_JNC, K_JB, K_JNB,
		K_BRANCH_BIT_SET_THEN_CLEAR, K_JMP_IND, K_JZ, K_JNZ, K_CMP_BNE, K_DEC_BNZ,
		K_CODE_STORE, K_BREAK
	} od_kind_t;

	typedef enum logic [3:0] {
		M_NONE, M_ACC, M_REG, M_IND, M_DIR, M_IMM, M_BIT, M_REL, M_DIR_IMM,
		M_DIR_DIR, M_CODE_DP, M_CODE_PC, M_XDP, M_XRI, M_ADDR11, M_ADDR16
	} od_mode_t;

	// --------------------------------------------------------------
	// Decoded instruction
	// --------------------------------------------------------------
	typedef struct packed {
		od_kind_t kind;
		od_mode_t mode;
		logic [2:0] reg_num;
		logic [1:0] len;
		logic [2:0] cyc;
		logic [3:0] flags;
		logic [2:0] page;
	} od_dec_t;

	typedef enum logic [1:0] {S_FETCH, S_OPER, S_EXEC, S_BREAK} od_st_t;

	typedef struct packed {
		od_st_t st;
		logic [7:0] opc;
		od_dec_t dec;
		logic [7:0] op1;
		logic [7:0] op2;
		logic [1:0] bytes_left;
		logic [2:0] mc_left;
		logic req;
		logic div_clr;
		logic issue;
		logic done;
		logic brk;
		logic halted;
	} od_state_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
	} od_div_state_t;

endpackage

//--- rtl/od_regs.svh
// Constants for the opcode decoder: lengths, cycle counts, flag masks.
// Assumes inclusion by od_pkg users only; definitions only.
`ifndef OD_REGS_SVH
`define OD_REGS_SVH

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define OD_CLK_MHZ 20
`define OD_CLK_PER_MC 2

// --------------------------------------------------------------
// Instruction lengths in bytes and times in machine cycles
// --------------------------------------------------------------
`define OD_L1 2'h1
`define OD_L2 2'h2
`define OD_L3 2'h3
`define OD_C1 3'h1
`define OD_C2 3'h2
`define OD_C4 3'h4

// --------------------------------------------------------------
// Flag effect masks: bit 3 carry, 2 aux carry, 1 overflow, 0 parity
// --------------------------------------------------------------
`define OD_FB_CY 3
`define OD_FB_AC 2
`define OD_FB_OV 1
`define OD_FB_P 0
`define OD_F_NONE 4'h0
`define OD_F_P 4'h1
`define OD_F_CY 4'h8
`define OD_F_CYP 4'h9
`define OD_F_MULDIV 4'hb
`define OD_F_ALL 4'hf

// --------------------------------------------------------------
// Extended opcode select value that picks the code store
// --------------------------------------------------------------
`define OD_EXT_SEL_STORE 4'h1

`endif

//--- verif/od_code_mem.sv
// Program memory model answering the decoder fetch handshake.
// Assumes the bench loads mem and fill by hierarchical reference.
`timescale 1ns/10ps
module od_code_mem (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic [1:0] wait_i,
	output logic valid_o,
	output logic [7:0] byte_o
);
	logic [7:0] mem [0:255];
	int fill = 0;
	int ptr = 0;
	logic [1:0] gap = 2'h0;
	initial begin
		valid_o = 1'b0;
		byte_o = 8'h00;
	end
	// --------------------------------------------------------------
	// Idle cycles show a toggling byte, so a stale value never passes
	// --------------------------------------------------------------
	always @(posedge clk_i) begin
		int p;
		logic [1:0] g;
		if (!rst_n_i) begin
			ptr <= 0;
			gap <= 2'h0;
			valid_o <= 1'b0;
		end else begin
			p = ptr;
			g = gap;
			if (valid_o && req_i) begin
				p = p + 1;
				g = wait_i;
			end else if (g != 2'h0)
				g = g - 2'h1;
			if (g == 2'h0 && p < fill) begin
				valid_o <= 1'b1;
				byte_o <= mem[p];
			end else begin
				valid_o <= 1'b0;
				byte_o <= ~byte_o;
			end
			ptr <= p;
			gap <= g;
		end
	end
endmodule

//--- verif/od_decoder_chk.sv
// Concurrent checks on the opcode decoder ports, bound into every od_decoder.
// Assumes one clock and the synchronous active-low reset of the design.
`timescale 1ns/10ps
module od_decoder_chk import od_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic code_valid_i,
	input wire logic [7:0] code_byte_i,
	input wire logic [3:0] ext_sel_i,
	input wire logic break_release_i,
	input wire logic code_req_o,
	input wire logic [7:0] opcode_o,
	input wire od_dec_t dec_o,
	input wire logic [7:0] operand1_o,
	input wire logic [7:0] operand2_o,
	input wire logic issue_o,
	input wire logic done_o,
	input wire logic break_o,
	input wire logic halted_o
);
	// --------------------------------------------------------------
	// Fetched byte count, cleared when the instruction issues
	// --------------------------------------------------------------
	logic [1:0] takes_r;
	logic [1:0] takes_nxt;
	always_comb begin
		takes_nxt = takes_r;
		if (issue_o)
			takes_nxt = 2'h0;
		if (code_req_o && code_valid_i)
			takes_nxt = takes_nxt + 2'h1;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			takes_r <= 2'h0;
		else
			takes_r <= takes_nxt;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	a_one_mc_time: assert property (issue_o && dec_o.cyc == `OD_C1 |->
		!done_o ##1 !done_o ##1 done_o) else $error("one cycle op not done after 2 clocks");
	a_two_mc_time: assert property (issue_o && dec_o.cyc == `OD_C2 |->
		(!done_o)[*4] ##1 done_o) else $error("two cycle op not done after 4 clocks");
	a_four_mc_time: assert property (issue_o && dec_o.cyc == `OD_C4 |->
		(!done_o)[*8] ##1 done_o) else $error("four cycle op not done after 8 clocks");
	a_byte_count: assert property (issue_o |-> dec_o.len == takes_r)
		else $error("fetched byte count differs from length");
	a_exec_quiet: assert property (issue_o |-> !code_req_o ##1 (!code_req_o && !issue_o))
		else $error("fetch or issue during execution");
	a_muldiv_cycles: assert property (issue_o && (opcode_o == 8'ha4 || opcode_o == 8'h84)
		|-> dec_o.cyc == `OD_C4 && dec_o.len == `OD_L1) else $error("mul or div timing wrong");
	a_reg_field: assert property (issue_o && opcode_o[7:3] inside {5'h05, 5'h07, 5'h13, 5'h17,
		5'h1b} |-> dec_o.reg_num == opcode_o[2:0]) else $error("register number wrong");
	a_abs_page: assert property (issue_o && opcode_o[3:0] == 4'h1 |->
		dec_o.page == opcode_o[7:5] && dec_o.mode == M_ADDR11) else $error("absolute page wrong");
	a_break_halt: assert property (break_o |-> done_o && halted_o ##1
		(halted_o && !code_req_o)) else $error("break did not halt");
	a_release_fetch: assert property (halted_o && break_release_i |-> ##[1:2] code_req_o)
		else $error("no fetch after break release");
endmodule

bind od_decoder od_decoder_chk u_chk (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.code_valid_i(code_valid_i),
	.code_byte_i(code_byte_i),
	.ext_sel_i(ext_sel_i),
	.break_release_i(break_release_i),
	.code_req_o(code_req_o),
	.opcode_o(opcode_o),
	.dec_o(dec_o),
	.operand1_o(operand1_o),
	.operand2_o(operand2_o),
	.issue_o(issue_o),
	.done_o(done_o),
	.break_o(break_o),
	.halted_o(halted_o)
);

//--- verif/od_decoder_tb_top.sv
// Self-checking bench for od_decoder fed by the program memory model.
// Assumes the checker is bound in and od_regs.svh is on the include path.
`timescale 1ns/10ps
`include "od_regs.svh"
module od_decoder_tb_top import od_pkg::*; ;
	logic clk_i, rst_n_i, code_valid_i, break_release_i;
	logic code_req_o, issue_o, done_o, break_o, halted_o;
	logic [7:0] code_byte_i, opcode_o, operand1_o, operand2_o;
	logic [3:0] ext_sel_i;
	logic [1:0] mem_wait;
	od_dec_t dec_o;
	int errors, checked, top;
	int cycles = 0;

	od_decoder DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .code_valid_i(code_valid_i),
		.code_byte_i(code_byte_i), .ext_sel_i(ext_sel_i), .break_release_i(break_release_i),
		.code_req_o(code_req_o), .opcode_o(opcode_o), .dec_o(dec_o), .operand1_o(operand1_o),
		.operand2_o(operand2_o), .issue_o(issue_o), .done_o(done_o), .break_o(break_o),
		.halted_o(halted_o));
	od_code_mem MEM (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(code_req_o), .wait_i(mem_wait),
		.valid_o(code_valid_i), .byte_o(code_byte_i));

	always #25 clk_i = ~clk_i;

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic wrap_up;
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask

	// Operands derive from the opcode so a swapped byte shows up
	task automatic run(input logic [7:0] op, input int len, input int cyc, input od_kind_t kind,
		input od_mode_t mode);
		int n;
		logic [7:0] b1;
		logic [7:0] b2;
		b1 = ~op;
		b2 = op ^ 8'h3c;
		@(posedge clk_i);
		MEM.mem[top] <= op;
		MEM.mem[top + 1] <= b1;
		MEM.mem[top + 2] <= b2;
		top = top + len;
		MEM.fill <= top;
		n = 0;
		do begin @(negedge clk_i); n++; end while (issue_o !== 1'b1 && n < 60);
		chk(opcode_o, op, "opcode");
		chk(dec_o.len, len, "length");
		chk(dec_o.cyc, cyc, "cycles");
		chk(dec_o.kind, kind, "operation");
		if (mode != M_NONE)
			chk(dec_o.mode, mode, "operand mode");
		chk(operand1_o, (len > 1) ? b1 : 8'h00, "operand one");
		chk(operand2_o, (len > 2) ? b2 : 8'h00, "operand two");
		if (op[7:3] inside {5'h05, 5'h07, 5'h13, 5'h17, 5'h1b})
			chk(dec_o.reg_num, op[2:0], "register");
		if (op[3:0] == 4'h1)
			chk(dec_o.page, op[7:5], "page");
		n = 0;
		do begin @(negedge clk_i); n++; end while (done_o !== 1'b1 && n < 20);
		chk(n, 2 * cyc, "execution clocks");
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_arith;
		run(8'h28, 1, 1, K_ADD, M_NONE);
		chk(dec_o.flags, `OD_F_ALL, "add flags");
		run(8'h3f, 1, 1, K_ADD_WITH_CARRY, M_NONE);
		run(8'h98, 1, 1, K_SUBTRACT_WITH_BORROW, M_NONE);
		run(8'h9f, 1, 1, K_SUBTRACT_WITH_BORROW, M_NONE);
		run(8'h94, 2, 1, K_SUBTRACT_WITH_BORROW, M_NONE);
		run(8'h33, 1, 1, K_ROTATE_LEFT_THROUGH_CARRY, M_NONE);
		chk(dec_o.flags, `OD_F_CYP, "rotate flags");
		run(8'h13, 1, 1, K_ROTATE_RIGHT_THROUGH_CARRY, M_NONE);
		run(8'ha4, 1, 4, K_MUL, M_NONE);
		chk(dec_o.flags, `OD_F_MULDIV, "multiply flags");
		run(8'h84, 1, 4, K_DIV, M_NONE);
	endtask

	// Slow memory stretches every operand fetch
	task automatic t_three;
		@(posedge clk_i);
		mem_wait <= 2'h2;
		run(8'h53, 3, 2, K_ANL, M_NONE);
		run(8'h43, 3, 2, K_ORL, M_NONE);
		run(8'h63, 3, 2, K_XRL, M_NONE);
		run(8'h85, 3, 2, K_MOV, M_DIR_DIR);
		run(8'hb4, 3, 2, K_CMP_BNE, M_NONE);
		run(8'hbf, 3, 2, K_CMP_BNE, M_NONE);
		run(8'hd5, 3, 2, K_DEC_BNZ, M_NONE);
		run(8'hd8, 2, 2, K_DEC_BNZ, M_NONE);
		run(8'h12, 3, 2, K_LONG_CALL, M_ADDR16);
		run(8'h02, 3, 2, K_LONG_JUMP, M_ADDR16);
		run(8'h10, 3, 2, K_BRANCH_BIT_SET_THEN_CLEAR, M_NONE);
	endtask

	task automatic t_moves;
		@(posedge clk_i);
		mem_wait <= 2'h1;
		run(8'h93, 1, 2, K_CODE_MOVE, M_CODE_DP);
		run(8'h83, 1, 2, K_CODE_MOVE, M_CODE_PC);
		run(8'he0, 1, 2, K_XMOVE_RD, M_XDP);
		run(8'hf0, 1, 2, K_XMOVE_WR, M_XDP);
		run(8'he2, 1, 2, K_XMOVE_RD, M_XRI);
		run(8'hf3, 1, 2, K_XMOVE_WR, M_XRI);
		run(8'hc0, 2, 2, K_PUSH, M_NONE);
		run(8'hd0, 2, 2, K_POP, M_NONE);
		run(8'hd7, 1, 1, K_XCH_NIB, M_NONE);
		run(8'hb0, 2, 2, K_ANL_CN, M_NONE);
		run(8'ha0, 2, 2, K_ORL_CN, M_NONE);
		run(8'h73, 1, 2, K_JMP_IND, M_NONE);
	endtask

	task automatic t_abs;
		@(posedge clk_i);
		mem_wait <= 2'h0;
		for (int i = 0; i < 8; i++) begin
			run({i[2:0], 5'h11}, 2, 2, K_ABS_CALL, M_ADDR11);
			run({i[2:0], 5'h01}, 2, 2, K_ABS_JUMP, M_ADDR11);
		end
	endtask

	task automatic t_break;
		int n;
		@(posedge clk_i);
		ext_sel_i <= 4'h2;
		run(8'ha5, 1, 1, K_BREAK, M_NONE);
		chk(break_o, 1'b1, "break pulse");
		repeat (5) begin
			@(negedge clk_i);
			chk({halted_o, code_req_o}, 2'b10, "halt holds");
		end
		@(posedge clk_i);
		break_release_i <= 1'b1;
		n = 0;
		do begin @(negedge clk_i); n++; end while (code_req_o !== 1'b1 && n < 4);
		chk(code_req_o, 1'b1, "fetch after release");
		@(posedge clk_i);
		break_release_i <= 1'b0;
		ext_sel_i <= `OD_EXT_SEL_STORE;
		run(8'ha5, 1, 2, K_CODE_STORE, M_NONE);
		chk(halted_o, 1'b0, "no halt on store");
	endtask

	// Hang guard, well above the fewer than a thousand clocks the run needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			wrap_up;
		end
	end

	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		ext_sel_i = 4'h0;
		break_release_i = 1'b0;
		mem_wait = 2'h0;
		errors = 0;
		checked = 0;
		top = 0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_arith;
		t_three;
		t_moves;
		t_abs;
		t_break;
		wrap_up;
	end
endmodule
